//--- src/php_host_port.sv
/*
  Host access logic for the colour palette: pixel mask, read and write
  palette indices, palette status, the three-step colour data port with its
  holding registers, the display lookup through the pixel mask and the
  internal/external palette strap.
  Assumes io_rd and io_wr are one-cycle strobes on core_clk from the bus
  front end, with io_addr and host_data_bus_in valid in the same cycle.
*/
// Functional notes
// - The access mode comes from the addressed port, the cycle direction and, for the data port, the index port written last.
// - Writing a start index to port 03C7 makes the device fetch that entry into an 18-bit holding register.
// - A data-port read returns a six-bit component in the low bits with the top two bits zero.
// - Data reads give red, green, blue, and after the third the read index steps by one.
// - Three data-port writes build an 18-bit value from their low six bits in red, green, blue order.
// - After the third component the value is stored at the write index, which then steps by one.
// - Status bits 0 and 1 read 0 after a write to 03C7 and 1 after a write to 03C8.
// - Reading port 03C7 returns the status in either mode without disturbing the sequence.
// - For display refresh the pixel mask is ANDed with the colour value to form the lookup index.
// - The pixel mask has no effect on host palette accesses and can be accessed at any time.
// - The pixel mask is not initialised by reset.
// - The reference pin level at reset release selects internal or external palette.
// - Palette reads always drive internal data, with a gate output for steering external data.
// - The palette holds 256 entries of 18 bits, three 6-bit components each.
`timescale 1ns/100ps
module php_host_port #(
  parameter int DEPTH = php_pkg::DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic             host_data_bus_oe,
  input  wire logic        vref_pin,
  input  wire logic [7:0]  pixel_color,
  output logic      [17:0] pixel_rgb,
  output logic             external_palette_sel,
  output logic             external_palette_gate
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  php_ram_if               ram_bus ();
  php_pkg::php_mode_t      mode;
  php_pkg::php_comp_t      comp_q;
  php_pkg::php_comp_t      comp_d;
  logic [7:0]              pixel_mask_q;
  logic [7:0]              pixel_mask_d;
  logic [7:0]              rd_index_q;
  logic [7:0]              rd_index_d;
  logic [7:0]              wr_index_q;
  logic [7:0]              wr_index_d;
  logic                    last_was_write_q;
  logic                    last_was_write_d;
  logic                    fetch_q;
  logic                    fetch_d;
  logic [17:0]             rd_hold_q;
  logic [17:0]             rd_hold_d;
  logic [17:0]             wr_hold_q;
  logic [17:0]             wr_hold_d;
  logic [7:0]              bus_out_q;
  logic [7:0]              bus_out_d;
  logic                    bus_oe_q;
  logic                    bus_oe_d;
  logic                    ram_wr_en;
  logic [17:0]             ram_wr_data;
  logic [5:0]              rd_comp;
  logic [5:0]              wr_comp;
  logic                    hit_mask;
  logic                    hit_rindex;
  logic                    hit_windex;
  logic                    hit_data;

  // ==========================================================================
  // Port decode and access mode.
  // ==========================================================================
  assign hit_mask   = (io_addr == php_pkg::PORT_PIXEL_MASK);
  assign hit_rindex = (io_addr == php_pkg::PORT_READ_INDEX);
  assign hit_windex = (io_addr == php_pkg::PORT_WRITE_INDEX);
  assign hit_data   = (io_addr == php_pkg::PORT_PALETTE_DATA);
  assign wr_comp    = host_data_bus_in[5:0];

  // The status read is decoded ahead of the data port, so reading it never steps the sequence.
  always_comb begin
    mode = php_pkg::php_mode_idle;
    if (io_rd || io_wr) begin
      if (hit_mask) begin
        mode = php_pkg::php_mode_mask;
      end else if (hit_rindex && io_rd) begin
        mode = php_pkg::php_mode_status;
      end else if ((hit_rindex && io_wr) || (hit_data && !last_was_write_q)) begin
        mode = php_pkg::php_mode_read;
      end else if (hit_windex || hit_data) begin
        mode = php_pkg::php_mode_write;
      end
    end
  end

  // ==========================================================================
  // Pixel mask.
  // ==========================================================================
  // The mask is only a register to the host and never gates host palette accesses.
  always_comb begin
    pixel_mask_d = pixel_mask_q;
    if (io_wr && hit_mask) begin
      pixel_mask_d = host_data_bus_in;
    end
  end

  // No reset: the mask stays undefined until software loads it.
  always_ff @(posedge core_clk) begin
    pixel_mask_q <= pixel_mask_d;
  end

  // ==========================================================================
  // Index, component and holding state.
  // ==========================================================================
  // Picks the component that a data read returns in read mode.
  always_comb begin
    case (comp_q)
      php_pkg::php_comp_red:   rd_comp = rd_hold_q[php_pkg::RED_LSB +: php_pkg::COMP_W];
      php_pkg::php_comp_green: rd_comp = rd_hold_q[php_pkg::GREEN_LSB +: php_pkg::COMP_W];
      php_pkg::php_comp_blue:  rd_comp = rd_hold_q[php_pkg::BLUE_LSB +: php_pkg::COMP_W];
      default:                 rd_comp = rd_hold_q[php_pkg::BLUE_LSB +: php_pkg::COMP_W];
    endcase
  end

  // ==========================================================================
  // Sequence update.
  // ==========================================================================
  // A fetch lands one cycle after an index write or a third data read, so the
  // host leaves one idle cycle before the next data read.
  // Both indices are eight bits wide, so the increment wraps from 255 to 0.
  always_comb begin
    comp_d           = comp_q;
    rd_index_d       = rd_index_q;
    wr_index_d       = wr_index_q;
    last_was_write_d = last_was_write_q;
    fetch_d          = 1'b0;
    rd_hold_d        = rd_hold_q;
    wr_hold_d        = wr_hold_q;
    ram_wr_en        = 1'b0;
    // Red and green come from the holding register and blue straight from the
    // bus, so the store happens in the cycle of the third write.
    ram_wr_data      = {wr_hold_q[php_pkg::GREEN_LSB +: 2 * php_pkg::COMP_W], wr_comp};
    if (fetch_q) begin
      rd_hold_d = ram_bus.host_data;
    end
    case (mode)
      php_pkg::php_mode_read: begin
        if (io_wr && hit_rindex) begin
          rd_index_d       = host_data_bus_in;
          last_was_write_d = 1'b0;
          comp_d           = php_pkg::php_comp_red;
          fetch_d          = 1'b1;
        end else if (io_rd) begin
          case (comp_q)
            php_pkg::php_comp_red:   comp_d = php_pkg::php_comp_green;
            php_pkg::php_comp_green: comp_d = php_pkg::php_comp_blue;
            default: begin
              comp_d     = php_pkg::php_comp_red;
              rd_index_d = rd_index_q + 8'h01;
              fetch_d    = 1'b1;
            end
          endcase
        end
      end
      php_pkg::php_mode_write: begin
        // Writing the index drops any partial triple; stale components are overwritten later.
        if (hit_windex && io_wr) begin
          wr_index_d       = host_data_bus_in;
          last_was_write_d = 1'b1;
          comp_d           = php_pkg::php_comp_red;
        end else if (io_wr) begin
          case (comp_q)
            php_pkg::php_comp_red: begin
              wr_hold_d[php_pkg::RED_LSB +: php_pkg::COMP_W] = wr_comp;
              comp_d = php_pkg::php_comp_green;
            end
            php_pkg::php_comp_green: begin
              wr_hold_d[php_pkg::GREEN_LSB +: php_pkg::COMP_W] = wr_comp;
              comp_d = php_pkg::php_comp_blue;
            end
            default: begin
              wr_hold_d[php_pkg::BLUE_LSB +: php_pkg::COMP_W] = wr_comp;
              ram_wr_en  = 1'b1;
              wr_index_d = wr_index_q + 8'h01;
              comp_d     = php_pkg::php_comp_red;
            end
          endcase
        end
      end
      // Status and mask cycles leave the indices and the component step alone.
      php_pkg::php_mode_status: begin
        comp_d = comp_q;
      end
      php_pkg::php_mode_mask: begin
        comp_d = comp_q;
      end
      default: begin
        comp_d = comp_q;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_q           <= php_pkg::php_comp_red;
      rd_index_q       <= php_pkg::INDEX_RESET;
      wr_index_q       <= php_pkg::INDEX_RESET;
      last_was_write_q <= 1'b0;
      fetch_q          <= 1'b0;
      rd_hold_q        <= php_pkg::HOLD_RESET;
      wr_hold_q        <= php_pkg::HOLD_RESET;
    end else begin
      comp_q           <= comp_d;
      rd_index_q       <= rd_index_d;
      wr_index_q       <= wr_index_d;
      last_was_write_q <= last_was_write_d;
      fetch_q          <= fetch_d;
      rd_hold_q        <= rd_hold_d;
      wr_hold_q        <= wr_hold_d;
    end
  end

  // ==========================================================================
  // Host read data.
  // ==========================================================================
  always_comb begin
    bus_out_d = bus_out_q;
    bus_oe_d  = 1'b0;
    if (io_rd) begin
      if (hit_mask) begin
        bus_oe_d  = 1'b1;
        bus_out_d = pixel_mask_q;
      end else if (hit_rindex) begin
        bus_oe_d  = 1'b1;
        bus_out_d = {php_pkg::STATUS_PAD,
                     last_was_write_q ? php_pkg::STATUS_WRITE : php_pkg::STATUS_READ};
      end else if (hit_windex) begin
        bus_oe_d  = 1'b1;
        bus_out_d = wr_index_q;
      end else if (hit_data) begin
        // Internal data is driven even when an external palette is used.
        bus_oe_d  = 1'b1;
        if (last_was_write_q) begin
          // In write mode the port shows the last blue written and does not step.
          bus_out_d = {php_pkg::COMP_PAD, wr_hold_q[php_pkg::BLUE_LSB +: php_pkg::COMP_W]};
        end else begin
          bus_out_d = {php_pkg::COMP_PAD, rd_comp};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_out_q <= php_pkg::BUS_IDLE;
      bus_oe_q  <= 1'b0;
    end else begin
      bus_out_q <= bus_out_d;
      bus_oe_q  <= bus_oe_d;
    end
  end

  assign host_data_bus_out = bus_out_q;
  assign host_data_bus_oe  = bus_oe_q;

  // Lets an external palette put its data on the bus during a data read.
  assign external_palette_gate = external_palette_sel && io_rd && hit_data;

  // ==========================================================================
  // Palette RAM, display lookup and strap.
  // ==========================================================================
  // Host reads use the read index unmasked; only the display lookup goes
  // through the pixel mask, and its data arrives one cycle later.
  assign ram_bus.wr_en     = ram_wr_en;
  assign ram_bus.wr_addr   = wr_index_q;
  assign ram_bus.wr_data   = ram_wr_data;
  assign ram_bus.host_addr = rd_index_q;
  assign ram_bus.disp_addr = pixel_color & pixel_mask_q;
  assign pixel_rgb         = ram_bus.disp_data;

  php_ram #(
    .DEPTH (DEPTH)
  ) u_ram (
    .core_clk (core_clk),
    .ram      (ram_bus)
  );

  // The strap is captured once after reset; only a new reset samples the pin again.
  php_strap u_strap (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .vref_pin (vref_pin),
    .ext_sel  (external_palette_sel)
  );

endmodule : php_host_port

//--- src/php_pkg.sv
/*
  Constants and types shared by the palette host port, its palette RAM and its
  reference-pin strap sampler.
  Assumes byte-wide host I/O cycles that are already synchronous to core_clk.
*/
package php_pkg;

  // ==========================================================================
  // Host I/O port addresses.
  // ==========================================================================
  localparam logic [15:0] PORT_PIXEL_MASK   = 16'h03c6;
  localparam logic [15:0] PORT_READ_INDEX   = 16'h03c7;
  localparam logic [15:0] PORT_WRITE_INDEX  = 16'h03c8;
  localparam logic [15:0] PORT_PALETTE_DATA = 16'h03c9;

  // ==========================================================================
  // Palette geometry and field layout.
  // ==========================================================================
  localparam int          COMP_W      = 6;
  localparam int          ENTRY_W     = 18;
  localparam int          INDEX_W     = 8;
  localparam int          DEPTH       = 256;
  localparam int          RED_LSB     = 12;
  localparam int          GREEN_LSB   = 6;
  localparam int          BLUE_LSB    = 0;
  localparam logic [1:0]  COMP_PAD    = 2'h0;

  // ==========================================================================
  // Status values and reset values.
  // ==========================================================================
  localparam logic [5:0]  STATUS_PAD      = 6'h00;
  localparam logic [1:0]  STATUS_READ     = 2'h0;
  localparam logic [1:0]  STATUS_WRITE    = 2'h3;
  localparam logic [7:0]  INDEX_RESET     = 8'h00;
  localparam logic [7:0]  BUS_IDLE        = 8'h00;
  localparam logic [17:0] HOLD_RESET      = 18'h00000;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [1:0] {
    php_comp_red,
    php_comp_green,
    php_comp_blue
  } php_comp_t;

  typedef enum logic [2:0] {
    php_mode_idle,
    php_mode_read,
    php_mode_write,
    php_mode_mask,
    php_mode_status
  } php_mode_t;

endpackage : php_pkg

//--- src/php_ram_if.sv
/*
  Connection between the palette host port and its palette RAM.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/100ps
interface php_ram_if;
  logic                         wr_en;
  logic [php_pkg::INDEX_W-1:0]  wr_addr;
  logic [php_pkg::ENTRY_W-1:0]  wr_data;
  logic [php_pkg::INDEX_W-1:0]  host_addr;
  logic [php_pkg::ENTRY_W-1:0]  host_data;
  logic [php_pkg::INDEX_W-1:0]  disp_addr;
  logic [php_pkg::ENTRY_W-1:0]  disp_data;

  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output host_addr,
    input  host_data,
    output disp_addr,
    input  disp_data
  );

  modport ram (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  host_addr,
    output host_data,
    input  disp_addr,
    output disp_data
  );
endinterface : php_ram_if

//--- src/php_ram.sv
/*
  Palette lookup RAM with one write port, an immediate host read port and a
  registered display read port.
  Assumes the controller holds host_addr stable while it samples host_data.
*/
`timescale 1ns/100ps
module php_ram #(
  parameter int DEPTH = php_pkg::DEPTH
) (
  input  wire logic core_clk,
  php_ram_if.ram    ram
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  logic [php_pkg::ENTRY_W-1:0] mem [DEPTH];
  logic [php_pkg::ENTRY_W-1:0] disp_data_q;
  logic [php_pkg::ENTRY_W-1:0] disp_data_d;

  // Palette contents are not cleared by reset, like the real cell array.
  always_ff @(posedge core_clk) begin
    if (ram.wr_en) begin
      mem[ram.wr_addr] <= ram.wr_data;
    end
  end

  // ==========================================================================
  // Read ports.
  // ==========================================================================
  always_comb begin
    disp_data_d = mem[ram.disp_addr];
  end

  always_ff @(posedge core_clk) begin
    disp_data_q <= disp_data_d;
  end

  assign ram.host_data = mem[ram.host_addr];
  assign ram.disp_data = disp_data_q;

endmodule : php_ram

//--- src/php_strap.sv
/*
  Samples the reference-voltage pin once after reset is released.
  Assumes the pin is asynchronous to core_clk and static around reset.
*/
`timescale 1ns/100ps
module php_strap (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic vref_pin,
  output logic      ext_sel
);

  // ==========================================================================
  // Three-stage synchroniser.
  // ==========================================================================
  logic       sync1_q;
  logic       sync2_q;
  logic       sync3_q;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       done_q;
  logic       done_d;
  logic       sel_q;
  logic       sel_d;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= vref_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ==========================================================================
  // Capture once the pipeline has filled and the last two stages agree.
  // ==========================================================================
  always_comb begin
    settle_d = settle_q;
    done_d   = done_q;
    sel_d    = sel_q;
    if (settle_q != php_pkg::STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end else if (!done_q && (sync2_q == sync3_q)) begin
      done_d = 1'b1;
      sel_d  = sync3_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
      done_q   <= 1'b0;
      sel_q    <= 1'b0;
    end else begin
      settle_q <= settle_d;
      done_q   <= done_d;
      sel_q    <= sel_d;
    end
  end

  assign ext_sel = sel_q;

endmodule : php_strap

//--- tb/php_host_bfm.sv
/*
  Host CPU model for the palette host port: byte I/O read and write cycles.
  Assumes strobes are sampled on the rising edge of core_clk.
*/
`timescale 1ns/100ps
module php_host_bfm (
  input  wire logic        core_clk,
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  host_data_bus_in,
  input  wire logic [7:0]  host_data_bus_out,
  input  wire logic        host_data_bus_oe
);
  initial begin
    io_addr          = 16'h0000;
    io_rd            = 1'b0;
    io_wr            = 1'b0;
    host_data_bus_in = 8'h00;
  end

  // Released lines show the inverse of their last value, never a stale copy.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr          = a;
    host_data_bus_in = d;
    io_wr            = 1'b1;
    @(posedge core_clk);
    #1;
    io_wr            = 1'b0;
    io_addr          = ~a;
    host_data_bus_in = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    d       = host_data_bus_out;
    oe      = host_data_bus_oe;
    io_rd   = 1'b0;
    io_addr = ~a;
  endtask : rd
endmodule : php_host_bfm

//--- tb/php_host_port_asserts.sv
/*
  Concurrent checks on the ports of the palette host port.
  Assumes it is bound into php_host_port and sees only its ports.
*/
`timescale 1ns/100ps
module php_host_port_asserts #(
  parameter int DEPTH = php_pkg::DEPTH
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  host_data_bus_in,
  input wire logic [7:0]  host_data_bus_out,
  input wire logic        host_data_bus_oe,
  input wire logic        vref_pin,
  input wire logic [7:0]  pixel_color,
  input wire logic [17:0] pixel_rgb,
  input wire logic        external_palette_sel,
  input wire logic        external_palette_gate
);
  logic       mode_q, mode_d, mvld_q, mvld_d, mapped;
  logic [7:0] mask_q, mask_d;
  logic [3:0] cnt_q, cnt_d;

  assign mapped = (io_addr >= php_pkg::PORT_PIXEL_MASK) && (io_addr <= php_pkg::PORT_PALETTE_DATA);

  always_comb begin
    mode_d = mode_q;
    mvld_d = mvld_q;
    mask_d = mask_q;
    cnt_d  = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
    if (io_wr && io_addr == php_pkg::PORT_READ_INDEX) mode_d = 1'b0;
    if (io_wr && io_addr == php_pkg::PORT_WRITE_INDEX) mode_d = 1'b1;
    if (io_wr && io_addr == php_pkg::PORT_PIXEL_MASK) begin
      mask_d = host_data_bus_in;
      mvld_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      mvld_q <= 1'b0;
      mask_q <= 8'h00;
      cnt_q  <= 4'h0;
    end else begin
      mode_q <= mode_d;
      mvld_q <= mvld_d;
      mask_q <= mask_d;
      cnt_q  <= cnt_d;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (io_rd && mapped |=> host_data_bus_oe)
    else $error("mapped read got no answer");
  a_quiet_bus: assert property (!(io_rd && mapped) |=> !host_data_bus_oe)
    else $error("bus driven without mapped read");
  a_out_hold: assert property (!(io_rd && mapped) |=> $stable(host_data_bus_out))
    else $error("read data changed without read");
  a_data_pad: assert property (io_rd && io_addr == php_pkg::PORT_PALETTE_DATA |=>
    host_data_bus_out[7:6] == php_pkg::COMP_PAD) else $error("data read top bits not zero");
  a_status_val: assert property (io_rd && io_addr == php_pkg::PORT_READ_INDEX |=>
    host_data_bus_out == {php_pkg::STATUS_PAD, mode_q ? php_pkg::STATUS_WRITE : php_pkg::STATUS_READ})
    else $error("status value wrong");
  a_mask_read: assert property (io_rd && io_addr == php_pkg::PORT_PIXEL_MASK && mvld_q |=>
    host_data_bus_out == mask_q) else $error("mask readback wrong");
  a_gate_form: assert property (external_palette_gate ==
    (external_palette_sel && io_rd && io_addr == php_pkg::PORT_PALETTE_DATA)) else $error("gate wrong");
  a_strap_hold: assert property (cnt_q == 4'hf |-> $stable(external_palette_sel))
    else $error("strap result changed");
endmodule : php_host_port_asserts

bind php_host_port php_host_port_asserts #(.DEPTH(DEPTH)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
  .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe(host_data_bus_oe), .vref_pin(vref_pin), .pixel_color(pixel_color),
  .pixel_rgb(pixel_rgb), .external_palette_sel(external_palette_sel),
  .external_palette_gate(external_palette_gate));

//--- tb/tb_palette_host_port.sv
/*
  Self-checking testbench for the palette host port.
  Assumes the host model php_host_bfm and the bound checker.
*/
`timescale 1ns/100ps
module tb_palette_host_port;
  logic        core_clk, rst_n, io_rd, io_wr, host_data_bus_oe, vref_pin;
  logic        external_palette_sel, external_palette_gate, rd_oe;
  logic [15:0] io_addr;
  logic [7:0]  host_data_bus_in, host_data_bus_out, pixel_color, rd_d;
  logic [17:0] pixel_rgb, ent;
  int          failures;
  int          num_checks;

  php_host_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .vref_pin(vref_pin), .pixel_color(pixel_color),
    .pixel_rgb(pixel_rgb), .external_palette_sel(external_palette_sel),
    .external_palette_gate(external_palette_gate));
  php_host_bfm host_u (.core_clk(core_clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string nm);
    host_u.rd(a, rd_d, rd_oe);
    chk({nm, "_oe"}, {17'h0, rd_oe}, 18'h1);
    chk(nm, {10'h0, rd_d}, {10'h0, exp});
  endtask : rdc

  function automatic logic [17:0] col(input logic [7:0] i);
    col = {i[5:0], ~i[5:0], i[5:0] ^ 6'h2a};
  endfunction : col

  // Upper bits of each write are set to show that they are dropped.
  task automatic wr_entry(input logic [17:0] e);
    host_u.wr(php_pkg::PORT_PALETTE_DATA, {2'h3, e[17:12]});
    host_u.wr(php_pkg::PORT_PALETTE_DATA, {2'h2, e[11:6]});
    host_u.wr(php_pkg::PORT_PALETTE_DATA, {2'h1, e[5:0]});
  endtask : wr_entry

  task automatic rd_entry(input logic [17:0] e);
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, e[17:12]}, "red");
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, e[11:6]}, "green");
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, e[5:0]}, "blue");
  endtask : rd_entry

  task automatic do_reset(input logic v);
    vref_pin = v;
    rst_n    = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
  endtask : do_reset

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    finish_test();
  end

  initial begin
    failures    = 0;
    num_checks  = 0;
    rst_n       = 1'b0;
    vref_pin    = 1'b1;
    pixel_color = 8'h00;
    do_reset(1'b1);
    chk("ext_sel", {17'h0, external_palette_sel}, 18'h1);
    rdc(php_pkg::PORT_READ_INDEX, 8'h00, "status_rst");
    host_u.wr(php_pkg::PORT_WRITE_INDEX, 8'hfe);
    for (int i = 0; i < 3; i++) wr_entry(col(8'hfe + i[7:0]));
    host_u.wr(16'h13c8, 8'h55);
    rdc(php_pkg::PORT_WRITE_INDEX, 8'h01, "wr_index");
    rdc(php_pkg::PORT_READ_INDEX, 8'h03, "status_wr");
    host_u.rd(16'h03c5, rd_d, rd_oe);
    chk("unmapped_oe", {17'h0, rd_oe}, 18'h0);
    host_u.wr(php_pkg::PORT_WRITE_INDEX, 8'h10);
    host_u.wr(php_pkg::PORT_PALETTE_DATA, 8'h2d);
    host_u.wr(php_pkg::PORT_WRITE_INDEX, 8'h10);
    ent = col(8'h10);
    wr_entry(ent);
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, ent[5:0]}, "wr_mode_data");
    host_u.wr(php_pkg::PORT_PIXEL_MASK, 8'h10);
    rdc(php_pkg::PORT_PIXEL_MASK, 8'h10, "mask");
    pixel_color = 8'hff;
    repeat (2) @(posedge core_clk);
    #1;
    chk("pixel_rgb_10", pixel_rgb, col(8'h10));
    host_u.wr(php_pkg::PORT_PIXEL_MASK, 8'hfe);
    repeat (2) @(posedge core_clk);
    #1;
    chk("pixel_rgb_fe", pixel_rgb, col(8'hfe));
    host_u.wr(php_pkg::PORT_READ_INDEX, 8'hfe);
    rdc(php_pkg::PORT_READ_INDEX, 8'h00, "status_rd");
    ent = col(8'hfe);
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, ent[17:12]}, "red_fe");
    rdc(php_pkg::PORT_READ_INDEX, 8'h00, "status_mid");
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, ent[11:6]}, "green_fe");
    rdc(php_pkg::PORT_PALETTE_DATA, {2'h0, ent[5:0]}, "blue_fe");
    rd_entry(col(8'hff));
    rd_entry(col(8'h00));
    host_u.wr(php_pkg::PORT_READ_INDEX, 8'h10);
    rd_entry(col(8'h10));
    do_reset(1'b0);
    chk("ext_sel_low", {17'h0, external_palette_sel}, 18'h0);
    rdc(php_pkg::PORT_READ_INDEX, 8'h00, "status_rst2");
    finish_test();
  end
endmodule : tb_palette_host_port
